// ===== pkg/tmc_regs.svh
// Register offsets, field positions, reset values and the rule summary for the timer control block.
// Assumes a 16-bit register port with a byte address and one-cycle read latency.
// Behaviour
// - Stage one divides by 1, 2, 4, 8
// - Mode 00b halts and holds the counter
// - Mode 01b counts up to latch zero, restarts
// - Mode 10b counts up to length maximum, wraps
// - Mode 11b counts up to latch zero, then down
// - Clear resets counter, prescaler and direction
// - Clear bit always reads back zero
// - Interrupt request forwarded only when enabled
// - Flag bit reads pending state, read/write
// - Pair bit 4 joins compare one and two
// - Pair bit 5 joins compare three and four
// - Pair bit 6 joins compare five and six
// - Clocking mode selects external, local, auxiliary clock
// - Reserved bits ignore writes, read zero
// - Length field sets continuous-mode maximum count
// - Source select picks timer, aux, subsystem, inverted
// - Capture-mode bits pick single or dual capture
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// Register byte offsets
`define TMC_OFF_MAIN 8'h00
`define TMC_OFF_CLOCKING 8'h02
`define TMC_OFF_COUNT 8'h04
`define TMC_OFF_CAPMODES 8'h06

// Main register field positions
`define TMC_MAIN_FLAG_BIT 0
`define TMC_MAIN_IRQEN_BIT 1
`define TMC_MAIN_CLEAR_BIT 2
`define TMC_MAIN_MODE_LSB 4
`define TMC_MAIN_DIV1_LSB 6
`define TMC_MAIN_SRC_LSB 8
`define TMC_MAIN_LEN_LSB 11
`define TMC_MAIN_GRP_LSB 13
// Stored bits of each control register; all others but the main clear bit are reserved
`define TMC_MAIN_WMASK 16'h7B_F3
`define TMC_CLK_WMASK 16'h07_73
`define TMC_CAP_WMASK 16'h00_7F

// Clocking register field positions
`define TMC_CLK_MODE_LSB 0
`define TMC_CLK_PAIR12_BIT 4
`define TMC_CLK_PAIR34_BIT 5
`define TMC_CLK_PAIR56_BIT 6
`define TMC_CLK_EXT_LSB 8

// Reset values
`define TMC_RESET_VALUE 16'h0000

// Continuous-mode maxima per length setting
`define TMC_MAX_16 16'hFFFF
`define TMC_MAX_12 16'h0FFF
`define TMC_MAX_10 16'h03FF
`define TMC_MAX_8 16'h00FF

`endif

// ===== pkg/tmc_pkg.sv
// Types for the timer control block.
// Assumes tmc_regs.svh holds the numeric constants.
package tmc_pkg;
  // Counting modes
  typedef enum logic [1:0] {
    TMC_MODE_STOP,
    TMC_MODE_UP,
    TMC_MODE_CONT,
    TMC_MODE_UPDOWN
  } tmc_mode_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tmc_bus_req_t;

  // Clock sources feeding the selector
  typedef struct packed {
    logic timer_clock_input;
    logic aux_clk;
    logic subsys_clk;
    logic hires_clk;
    logic peer_aux_clk;
  } tmc_clk_src_t;
endpackage

// ===== hdl/tmc_timer_control.sv
// Timer control: three control registers, prescaler, counter and overflow flag.
// Source clocks arrive as levels synchronous to ref_clk; rising edges make the ticks.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "tmc_regs.svh"

module tmc_timer_control #(
  parameter int CHANNELS = 7 // 3, 5 or 7 compare channels
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire tmc_pkg::tmc_bus_req_t bus_req,
  input wire tmc_pkg::tmc_clk_src_t clk_src,
  input wire logic [15:0] compare_latch_zero,
  output logic [15:0] rdata,
  output logic [15:0] count_value,
  output logic irq,
  output logic [2:0] pair_out,
  output logic [1:0] clocking_mode_select,
  output logic [1:0] latch_group,
  output logic [6:0] capture_dual
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] main_reg; // Main control, clear bit never stored
  logic [15:0] clk_reg; // Clocking control
  logic [15:0] cap_reg; // Capture modes
  logic [15:0] count_reg; // Counter value
  logic down_reg; // Up/down direction, high while counting down
  logic src_prev_reg; // Selected source, previous sample
  logic [2:0] div1_cnt_reg; // Stage one divider count
  logic [2:0] div2_cnt_reg; // Extension divider count
  logic stage1_tick; // Stage one output enable
  logic count_tick; // Effective count enable
  logic src_now; // Selected source level
  logic wrap; // Counter reaches end of count on this tick
  logic [15:0] count_next;
  logic down_next;
  logic [15:0] max_count; // Continuous-mode maximum
  logic [1:0] div1_sel;
  logic [2:0] div2_sel;
  logic [2:0] div1_lim; // Stage one terminal count
  logic wr_main;
  logic clear_req;
  tmc_pkg::tmc_mode_t mode;

  // Decoded fields
  assign wr_main = bus_req.wr && (bus_req.addr == `TMC_OFF_MAIN);
  assign clear_req = wr_main && bus_req.wdata[`TMC_MAIN_CLEAR_BIT];
  assign mode = tmc_pkg::tmc_mode_t'(main_reg[`TMC_MAIN_MODE_LSB +: 2]);
  assign div1_sel = main_reg[`TMC_MAIN_DIV1_LSB +: 2];
  assign div2_sel = clk_reg[`TMC_CLK_EXT_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection
  always_comb begin
    src_now = 1'b0;
    case (clk_reg[`TMC_CLK_MODE_LSB +: 2])
      2'b00: begin
        // External: source select picks the input
        case (main_reg[`TMC_MAIN_SRC_LSB +: 2])
          2'b00: src_now = clk_src.timer_clock_input;
          2'b01: src_now = clk_src.aux_clk;
          2'b10: src_now = clk_src.subsys_clk;
          default: src_now = ~clk_src.timer_clock_input;
        endcase
      end
      2'b01: src_now = clk_src.hires_clk;
      2'b10: src_now = clk_src.peer_aux_clk;
      default: src_now = 1'b0; // Reserved mode gives no ticks
    endcase
  end

  // Source edge sampler
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: two cascaded dividers driven by source rising edges
  always_comb begin
    // Divide by 1, 2, 4 or 8
    case (div1_sel)
      2'b00: div1_lim = 3'h0;
      2'b01: div1_lim = 3'h1;
      2'b10: div1_lim = 3'h3;
      default: div1_lim = 3'h7;
    endcase
  end

  assign stage1_tick = src_now && !src_prev_reg && (div1_cnt_reg == div1_lim);
  // Extension ratio is field value plus one; cascade gives the product
  assign count_tick = stage1_tick && (div2_cnt_reg == div2_sel);

  // Stage one counter; stopped mode freezes it to save toggling
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div1_cnt_reg <= 3'h0;
    end else if (clear_req) begin
      div1_cnt_reg <= 3'h0;
    end else if (mode != tmc_pkg::TMC_MODE_STOP && src_now && !src_prev_reg) begin
      div1_cnt_reg <= stage1_tick ? 3'h0 : div1_cnt_reg + 3'h1;
    end
  end

  // Extension counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div2_cnt_reg <= 3'h0;
    end else if (clear_req) begin
      div2_cnt_reg <= 3'h0;
    end else if (mode != tmc_pkg::TMC_MODE_STOP && stage1_tick) begin
      div2_cnt_reg <= count_tick ? 3'h0 : div2_cnt_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter next value
  always_comb begin
    // Length field maximum
    case (main_reg[`TMC_MAIN_LEN_LSB +: 2])
      2'b00: max_count = `TMC_MAX_16;
      2'b01: max_count = `TMC_MAX_12;
      2'b10: max_count = `TMC_MAX_10;
      default: max_count = `TMC_MAX_8;
    endcase
    count_next = count_reg;
    down_next = down_reg;
    wrap = 1'b0;
    case (mode)
      tmc_pkg::TMC_MODE_STOP: begin
        count_next = count_reg;
      end
      tmc_pkg::TMC_MODE_UP: begin
        // Restart from zero after latch zero; overflow on the step back
        if (count_reg >= compare_latch_zero) begin
          count_next = 16'h0000;
          wrap = 1'b1;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end
      tmc_pkg::TMC_MODE_CONT: begin
        if (count_reg >= max_count) begin
          count_next = 16'h0000;
          wrap = 1'b1;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end
      default: begin
        // Up/down: turn at latch zero, overflow flag when reaching zero
        if (down_reg) begin
          if (count_reg <= 16'h0001) begin
            count_next = 16'h0000;
            down_next = 1'b0;
            wrap = 1'b1;
          end else begin
            count_next = count_reg - 16'h0001;
          end
        end else if (count_reg >= compare_latch_zero) begin
          down_next = 1'b1;
          count_next = (count_reg == 16'h0000) ? 16'h0000 : count_reg - 16'h0001;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end
    endcase
  end

  // Counter and direction
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_reg <= `TMC_RESET_VALUE;
      down_reg <= 1'b0;
    end else if (clear_req) begin
      count_reg <= `TMC_RESET_VALUE;
      down_reg <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == `TMC_OFF_COUNT) begin
      // A direct write causes no count action
      count_reg <= bus_req.wdata;
    end else if (count_tick) begin
      count_reg <= count_next;
      down_reg <= down_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main control register; flag set wins over a write of flag zero, but a write with the clear bit wins over flag set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_reg <= `TMC_RESET_VALUE;
    end else begin
      if (wr_main) begin
        main_reg <= bus_req.wdata & `TMC_MAIN_WMASK;
      end
      if (count_tick && wrap && mode != tmc_pkg::TMC_MODE_STOP && !clear_req) begin
        main_reg[`TMC_MAIN_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Clocking register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_reg <= `TMC_RESET_VALUE;
    end else if (bus_req.wr && bus_req.addr == `TMC_OFF_CLOCKING) begin
      clk_reg <= bus_req.wdata & `TMC_CLK_WMASK;
    end
  end

  // Capture-mode register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_reg <= `TMC_RESET_VALUE;
    end else if (bus_req.wr && bus_req.addr == `TMC_OFF_CAPMODES) begin
      cap_reg <= bus_req.wdata & `TMC_CAP_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (!bus_req.rd) begin
      rdata <= 16'h0000;
    end else if (bus_req.addr == `TMC_OFF_MAIN) begin
      rdata <= main_reg;
    end else if (bus_req.addr == `TMC_OFF_CLOCKING) begin
      rdata <= clk_reg;
    end else if (bus_req.addr == `TMC_OFF_COUNT) begin
      rdata <= count_reg;
    end else if (bus_req.addr == `TMC_OFF_CAPMODES) begin
      rdata <= cap_reg;
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward the channel logic
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
      count_value <= 16'h0000;
      pair_out <= 3'h0;
      clocking_mode_select <= 2'h0;
      latch_group <= 2'h0;
      capture_dual <= 7'h00;
    end else begin
      irq <= main_reg[`TMC_MAIN_FLAG_BIT] && main_reg[`TMC_MAIN_IRQEN_BIT];
      count_value <= count_reg;
      pair_out[0] <= clk_reg[`TMC_CLK_PAIR12_BIT];
      // Pairs beyond the instance's channels stay unpaired
      pair_out[1] <= (CHANNELS >= 5) && clk_reg[`TMC_CLK_PAIR34_BIT];
      pair_out[2] <= (CHANNELS >= 7) && clk_reg[`TMC_CLK_PAIR56_BIT];
      clocking_mode_select <= clk_reg[`TMC_CLK_MODE_LSB +: 2];
      latch_group <= main_reg[`TMC_MAIN_GRP_LSB +: 2];
      capture_dual <= cap_reg[6:0];
    end
  end

endmodule // tmc_timer_control

// ===== verif/tmc_ctl_asserts.sv
// Port checker for the timer control block.
// Assumes it is bound onto tmc_timer_control; it shadows register writes itself.
`timescale 1ns/10ps
`include "tmc_regs.svh"
module tmc_ctl_asserts #(
  parameter int CHANNELS = 7 // Same channel count as the design
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire tmc_pkg::tmc_bus_req_t bus_req,
  input wire tmc_pkg::tmc_clk_src_t clk_src,
  input wire logic [15:0] compare_latch_zero,
  input wire logic [15:0] rdata,
  input wire logic [15:0] count_value,
  input wire logic irq,
  input wire logic [2:0] pair_out,
  input wire logic [1:0] clocking_mode_select,
  input wire logic [1:0] latch_group,
  input wire logic [6:0] capture_dual
);
  logic [15:0] main_q; // Shadow of main register; flag bit unused
  logic [15:0] clk_q; // Shadow of clocking register
  logic [15:0] cap_q; // Shadow of capture-mode register
  logic rd_q; // A read was taken last edge
  logic [7:0] ra_q; // Address of that read
  logic [15:0] wm; // Bits allowed to read non-zero
  logic [2:0] pm; // Pair bits this instance implements
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////
  // Shadow writes on the same edge the block takes them
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_q <= '0;
      clk_q <= '0;
      cap_q <= '0;
      rd_q <= 1'b0;
      ra_q <= '0;
    end else begin
      rd_q <= bus_req.rd;
      ra_q <= bus_req.addr;
      if (bus_req.wr && bus_req.addr == `TMC_OFF_MAIN) main_q <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == `TMC_OFF_CLOCKING) clk_q <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == `TMC_OFF_CAPMODES) cap_q <= bus_req.wdata;
    end
  end
  // Unmapped places must read all zero
  always_comb begin
    case (ra_q)
      `TMC_OFF_MAIN: wm = `TMC_MAIN_WMASK;
      `TMC_OFF_CLOCKING: wm = `TMC_CLK_WMASK;
      `TMC_OFF_COUNT: wm = 16'hFFFF;
      `TMC_OFF_CAPMODES: wm = `TMC_CAP_WMASK;
      default: wm = 16'h0000;
    endcase
  end
  assign pm = {CHANNELS >= 7, CHANNELS >= 5, 1'b1};
  //////////////////////////////////////////////////////////////////////
  a_idle_read: assert property (!rd_q |-> rdata == 16'h0000)
    else $error("read data not zero outside an answer");
  a_reserved_zero: assert property (rd_q |-> (rdata & ~wm) == 16'h0000)
    else $error("reserved or clear bit read non-zero");
  a_stop_holds: assert property
    ((main_q[5:4] == 2'b00 && !bus_req.wr) [*3] |=> $stable(count_value))
    else $error("count moved in stop mode");
  a_irq_gate: assert property (irq |-> $past(main_q[1]))
    else $error("interrupt raised while disabled");
  a_clear_zero: assert property
    (bus_req.wr && bus_req.addr == `TMC_OFF_MAIN && bus_req.wdata[2] |=> ##1 count_value == 0)
    else $error("clear did not zero the count");
  a_pair_copy: assert property (pair_out == ($past(clk_q[6:4]) & pm))
    else $error("pairing output wrong");
  a_clkmode_copy: assert property (clocking_mode_select == $past(clk_q[1:0]))
    else $error("clocking mode output wrong");
  a_capdual_copy: assert property (capture_dual == $past(cap_q[6:0]))
    else $error("capture mode output wrong");
  a_group_copy: assert property (latch_group == $past(main_q[14:13]))
    else $error("latch group output wrong");
  c_irq: cover property ($rose(irq));
  c_updown: cover property (main_q[5:4] == 2'b11 && count_value != 16'h0000);
  c_clear: cover property (bus_req.wr && bus_req.addr == `TMC_OFF_MAIN && bus_req.wdata[2]);
endmodule // tmc_ctl_asserts

bind tmc_timer_control tmc_ctl_asserts #(.CHANNELS(CHANNELS)) i_tmc_ctl_asserts (
  .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .clk_src(clk_src),
  .compare_latch_zero(compare_latch_zero), .rdata(rdata), .count_value(count_value),
  .irq(irq), .pair_out(pair_out), .clocking_mode_select(clocking_mode_select),
  .latch_group(latch_group), .capture_dual(capture_dual));

// ===== verif/tmc_timer_control_bench.sv
// Self-checking bench for the timer control block.
// Assumes the checker binds itself; the bench drives every port directly.
`timescale 1ns/10ps
`include "tmc_regs.svh"
module tmc_timer_control_bench;
  logic ref_clk = 1'b0; // 125 MHz
  logic reset = 1'b1;
  tmc_pkg::tmc_bus_req_t bus_req = '0;
  tmc_pkg::tmc_clk_src_t clk_src = '0; // Only the timer clock input toggles
  logic [15:0] compare_latch_zero = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] count_value;
  logic irq;
  logic [2:0] pair_out;
  logic [1:0] clocking_mode_select;
  logic [1:0] latch_group;
  logic [6:0] capture_dual;
  logic [15:0] exp_q[$]; // Expected read answers, oldest first
  logic rd_d = 1'b0; // An answer is due this edge
  logic [15:0] d;
  logic [15:0] wmask[4] = '{`TMC_MAIN_WMASK, `TMC_CLK_WMASK, 16'hFFFF, `TMC_CAP_WMASK};
  int err_total = 0;
  int checks = 0;
  tmc_timer_control #(.CHANNELS(7)) i_tmc_timer_control (
    .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .clk_src(clk_src),
    .compare_latch_zero(compare_latch_zero), .rdata(rdata), .count_value(count_value),
    .irq(irq), .pair_out(pair_out), .clocking_mode_select(clocking_mode_select),
    .latch_group(latch_group), .capture_dual(capture_dual));
  always #4 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task wr(input logic [7:0] a, input logic [15:0] v);
    bus_req.addr <= a;
    bus_req.wdata <= v;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Source edges four cycles apart, well under half the bus clock
  task tick(input int n);
    repeat (n) begin
      clk_src.timer_clock_input <= 1'b1;
      repeat (2) @(posedge ref_clk);
      clk_src.timer_clock_input <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // Answers land one cycle after the read strobe
  always @(posedge ref_clk) begin
    if (rd_d && exp_q.size() > 0) cmp(rdata, exp_q.pop_front());
    rd_d <= bus_req.rd;
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    close_out;
  end
  initial begin
    void'($urandom(32'hef17));
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) rd(8'(2 * i), 16'h0000);
    repeat (3) for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      // Keep the main register stopped so a stray source edge cannot set the flag
      if (i == 0) d[5:4] = 2'b00;
      wr(8'(2 * i), d);
      rd(8'(2 * i), d & wmask[i]);
    end
    wr(8'h08, 16'hFFFF);
    rd(8'h08, 16'h0000);
    // Up mode, divide 2 by 2, top 5
    compare_latch_zero <= 16'h0005;
    wr(`TMC_OFF_CLOCKING, 16'h0100);
    wr(`TMC_OFF_MAIN, 16'h0056);
    tick(12);
    rd(`TMC_OFF_COUNT, 16'h0003);
    tick(12);
    rd(`TMC_OFF_MAIN, 16'h0053);
    cmp({15'h0000, irq}, 16'h0001);
    tick(12);
    wr(`TMC_OFF_MAIN, 16'h0040);
    tick(8);
    rd(`TMC_OFF_COUNT, 16'h0003);
    cmp({15'h0000, irq}, 16'h0000);
    // Continuous mode, 8-bit length, wrap from near the top
    wr(`TMC_OFF_CLOCKING, 16'h0000);
    wr(`TMC_OFF_MAIN, 16'h1824);
    wr(`TMC_OFF_COUNT, 16'h00FE);
    tick(2);
    rd(`TMC_OFF_MAIN, 16'h1821);
    rd(`TMC_OFF_COUNT, 16'h0000);
    // Up/down with top 2: 1, 2, 1 then 0 sets the flag
    compare_latch_zero <= 16'h0002;
    wr(`TMC_OFF_MAIN, 16'h0034);
    tick(3);
    rd(`TMC_OFF_COUNT, 16'h0001);
    tick(1);
    rd(`TMC_OFF_MAIN, 16'h0031);
    // Inverted timer clock: the write itself makes the first edge, then one per tick
    wr(`TMC_OFF_MAIN, 16'h0324);
    tick(2);
    rd(`TMC_OFF_COUNT, 16'h0003);
    wr(`TMC_OFF_MAIN, 16'h0000);
    for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge ref_clk);
    if (exp_q.size() > 0) err_total++;
    close_out;
  end
endmodule // tmc_timer_control_bench
